// ===== src/aof_pkg.sv
package aof_pkg;

	// Register word offsets on the plain register port.
	localparam logic [3:0] REG_CTL    = 4'h0;
	localparam logic [3:0] REG_FIRST_BUFFER_BASE  = 4'h1;
	localparam logic [3:0] REG_SECOND_BUFFER_BASE  = 4'h2;
	localparam logic [3:0] REG_SIZE   = 4'h3;
	localparam logic [3:0] REG_STATUS = 4'h4;

	// Unit control register bit positions.
	localparam int CTL_RESET    = 31;
	localparam int CTL_TRANS    = 0;
	localparam int CTL_LITTLE   = 1;
	localparam int CTL_SIGN     = 2;
	localparam int CTL_INT1     = 3;
	localparam int CTL_INT2     = 4;
	localparam int CTL_UDRINT   = 5;
	localparam int CTL_FIRST_REFILL_ACK     = 6;
	localparam int CTL_SECOND_REFILL_ACK     = 7;
	localparam int CTL_ACKUDR   = 8;
	localparam int CTL_FMT_LO   = 9;
	localparam int CTL_LANE_LO  = 11;

	// Exact value that requests the unit software reset.
	localparam logic [31:0] SOFT_RESET_VALUE = 32'h8000_0000;

	// Reset values.
	localparam logic [1:0]  FMT_RESET  = 2'h0;
	localparam logic [1:0]  LANE_RESET = 2'h0;
	localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

	// Sample formats.
	typedef enum logic [1:0] {
		AOF_MONO32   = 2'b00,
		AOF_STEREO32 = 2'b01,
		AOF_MONO16   = 2'b10,
		AOF_STEREO16 = 2'b11
	} aof_fmt_e;

	// Fetch engine states.
	typedef enum logic [1:0] {
		AOF_IDLE  = 2'b00,
		AOF_READ  = 2'b01,
		AOF_WAIT  = 2'b10,
		AOF_HAND  = 2'b11
	} aof_state_e;

endpackage : aof_pkg

// ===== src/aof_sample_fetch.sv
// Operation
// - Spread samples over one to four lanes.
// - Fetch addresses never decrease within buffer; 16-bit formats fetch each word twice.
// - Byte order bit selects big or little.
// - Optional MSB inversion of fetched samples.
// - Idle lanes carry inverted-MSB zeros too.
// - Codec control fields never get inverted.
// - Chip reset or 0x80000000 resets unit.
// - Processor-only reset leaves unit alone.
// - Timestamp cleared by chip/processor reset only.
// - Reset: transmit off, buffer one current.
// - Drain buffer one, flag, continue buffer two.
// - Drained buffer one raises enabled interrupt.
// - Size counts samples or pairs per buffer.
// - Format decode; mono duplicates left to right.
// - Acknowledge clears drained flag, reads zero.
// - Missing buffer: no samples, sticky underrun.
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
module aof_sample_fetch
	import aof_pkg::*;
(
	input  wire logic        clk,          // System clock, 125 MHz.
	input  wire logic        rst_n,        // Chip reset, active low.
	input  wire logic        cpuRst,       // Processor-only reset pulse.
	input  wire logic [3:0]  regAddr,      // Register word index.
	input  wire logic [31:0] regWdata,     // Register write data.
	input  wire logic        regWr,        // Write strobe.
	input  wire logic        regRd,        // Read strobe.
	output logic      [31:0] regRdata,     // Read data, one cycle later.
	output logic      [31:0] memAddr,      // Memory read byte address.
	output logic             memReq,       // Memory read request.
	input  wire logic        memGnt,       // Memory accepted request.
	input  wire logic [31:0] memRdata,     // Memory read data.
	input  wire logic        memRvalid,    // Memory read data valid.
	input  wire logic        frameReq,     // Formatter wants next frame.
	output logic             frameValid,   // Frame of lane samples ready.
	output logic [31:0]      laneLeft  [4],// Left sample for each lane.
	output logic [31:0]      laneRight [4],// Right sample for each lane.
	output logic             irqReq,       // Interrupt request level.
	output logic [63:0]      timestamp     // Free-running timestamp.
);

	////////////////////////////////////////////////////////////////////////
	// Control and status storage.

	logic        unitRst;                  // Chip or software unit reset.
	logic        softRst_r;                // Software reset, one cycle.
	logic        transmitOn_r;             // Transmission enable.
	logic        littleEnd_r;              // Little endian byte order.
	logic        signInv_r;                // MSB invert enable.
	logic        firstDrainIrqEn_r;        // Buffer one interrupt enable.
	logic        secondDrainIrqEn_r;       // Buffer two interrupt enable.
	logic        udrIrqEn_r;               // Underrun interrupt enable.
	logic [1:0]  fmt_r;                    // Sample format select.
	logic [1:0]  laneCount_r;              // Active lanes minus one.
	logic [31:0] firstBase_r;              // Buffer one base address.
	logic [31:0] secondBase_r;             // Buffer two base address.
	logic [31:0] length_r;                 // Buffer size in samples or pairs.
	logic        firstCurrent_r;           // Buffer one supplies next.
	logic        firstDrained_r;           // Buffer one drained flag.
	logic        secondDrained_r;          // Buffer two drained flag.
	logic        underrun_r;               // Sticky underrun flag.
	logic        ctlWr;                    // Write to unit control.
	logic        first_refill_ack;                     // Buffer one acknowledge.
	logic        second_refill_ack;                     // Buffer two acknowledge.
	logic        ackUdr;                   // Underrun acknowledge.

	// Fetch engine.
	aof_state_e  state_r;                  // Fetch state.
	logic [31:0] offset_r;                 // Byte offset in buffer.
	logic [31:0] bufBytes;                 // Buffer length in bytes.
	logic [2:0]  slot_r;                   // Sample slot within frame.
	logic [2:0]  lastSlot;                 // Final slot of one frame.
	logic [31:0] sample;                   // Decoded, converted sample.
	logic        bufEnd;                   // Fetched last buffer word.
	logic        curDrained;               // Current buffer is drained.
	logic [31:0] stageL [4];               // Frame being assembled, left.
	logic [31:0] stageR [4];               // Frame being assembled, right.

	// Byte order and width decode, used by the fetch datapath.
	function automatic logic [31:0] decode(input logic [31:0] w,
		input logic is16, input logic le, input logic hi);
		logic [15:0] h;
		h = hi ? w[31:16] : w[15:0];
		if (is16)
			decode = le ? {h, 16'h0000} : {h[7:0], h[15:8], 16'h0000};
		else
			decode = le ? w : {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction : decode

	////////////////////////////////////////////////////////////////////////
	// Reset handling.

	// Soft reset is delayed a cycle so the write itself completes.
	// unit reset sources
	assign ctlWr   = regWr && (regAddr == REG_CTL);
	assign unitRst = !rst_n || softRst_r;

	always_ff @(posedge clk) begin
		if (!rst_n)
			softRst_r <= 1'b0;
		else
			softRst_r <= ctlWr && (regWdata == SOFT_RESET_VALUE);
	end

	always_ff @(posedge clk) begin
		if (!rst_n || cpuRst)
			timestamp <= 64'h0000_0000_0000_0000;
		else
			timestamp <= timestamp + 64'h0000_0000_0000_0001;
	end

	////////////////////////////////////////////////////////////////////////
	// Register writes.

	// Acknowledges are write-only pulses; they never store a value.
	assign first_refill_ack   = ctlWr && regWdata[CTL_FIRST_REFILL_ACK];
	assign second_refill_ack   = ctlWr && regWdata[CTL_SECOND_REFILL_ACK];
	assign ackUdr = ctlWr && regWdata[CTL_ACKUDR];

	always_ff @(posedge clk) begin
		if (unitRst) begin
			transmitOn_r       <= 1'b0;
			littleEnd_r        <= 1'b0;
			signInv_r          <= 1'b0;
			firstDrainIrqEn_r  <= 1'b0;
			secondDrainIrqEn_r <= 1'b0;
			udrIrqEn_r         <= 1'b0;
			fmt_r              <= FMT_RESET;
			laneCount_r        <= LANE_RESET;
		end else if (ctlWr && !regWdata[CTL_RESET]) begin
			transmitOn_r       <= regWdata[CTL_TRANS];
			littleEnd_r        <= regWdata[CTL_LITTLE];
			signInv_r          <= regWdata[CTL_SIGN];
			firstDrainIrqEn_r  <= regWdata[CTL_INT1];
			secondDrainIrqEn_r <= regWdata[CTL_INT2];
			udrIrqEn_r         <= regWdata[CTL_UDRINT];
			fmt_r              <= regWdata[CTL_FMT_LO +: 2];
			laneCount_r        <= regWdata[CTL_LANE_LO +: 2];
		end
	end

	// Buffer descriptors; software keeps bases aligned and sizes whole.
	always_ff @(posedge clk) begin
		if (unitRst) begin
			firstBase_r  <= ADDR_RESET;
			secondBase_r <= ADDR_RESET;
			length_r     <= ADDR_RESET;
		end else if (regWr) begin
			if (regAddr == REG_FIRST_BUFFER_BASE)
				firstBase_r <= regWdata;
			if (regAddr == REG_SECOND_BUFFER_BASE)
				secondBase_r <= regWdata;
			if (regAddr == REG_SIZE)
				length_r <= regWdata;
		end
	end

	// Read data stand in the cycle after the strobe; acks read zero.
	// acknowledge reads zero
	always_ff @(posedge clk) begin
		if (unitRst)
			regRdata <= 32'h0000_0000;
		else if (!regRd)
			regRdata <= 32'h0000_0000;
		else begin
			case (regAddr)
				REG_CTL:    regRdata <= {19'h00000, laneCount_r, fmt_r,
					3'h0, udrIrqEn_r, secondDrainIrqEn_r,
					firstDrainIrqEn_r, signInv_r, littleEnd_r,
					transmitOn_r};
				REG_FIRST_BUFFER_BASE:  regRdata <= firstBase_r;
				REG_SECOND_BUFFER_BASE:  regRdata <= secondBase_r;
				REG_SIZE:   regRdata <= length_r;
				REG_STATUS: regRdata <= {28'h0000000, underrun_r,
					secondDrained_r, firstDrained_r, firstCurrent_r};
				default:    regRdata <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Fetch datapath.

	always_comb begin
		case (aof_fmt_e'(fmt_r))
			AOF_MONO16:   bufBytes = {length_r[30:0], 1'b0};
			AOF_MONO32:   bufBytes = {length_r[29:0], 2'b00};
			AOF_STEREO16: bufBytes = {length_r[29:0], 2'b00};
			default:      bufBytes = {length_r[28:0], 3'b000};
		endcase
	end

	assign lastSlot = fmt_r[0] ? {laneCount_r, 1'b1} : {1'b0, laneCount_r};
	assign curDrained = firstCurrent_r ? firstDrained_r : secondDrained_r;

	// MSB inversion
	// A 16-bit sample is carried MSB-aligned in the 32-bit lane word.
	// Byte lanes are little endian: the lowest address sits in bits 7:0,
	// so the upper half holds the odd half-word for either byte order.
	assign sample = decode(memRdata, fmt_r[1], littleEnd_r, offset_r[1])
		^ {signInv_r, 31'h00000000};

	assign memAddr = (firstCurrent_r ? firstBase_r : secondBase_r)
		+ {offset_r[31:2], 2'b00};
	assign memReq  = (state_r == AOF_READ);
	assign bufEnd  = (offset_r + (fmt_r[1] ? 32'h2 : 32'h4)) >= bufBytes;

	// Fetch sequence: read one sample, place it, hand out a full frame.
	// no samples when starved
	always_ff @(posedge clk) begin
		if (unitRst) begin
			state_r <= AOF_IDLE;
			offset_r <= 32'h0000_0000;
			slot_r <= 3'h0;
			firstCurrent_r <= 1'b1;
		end else begin
			case (state_r)
				AOF_IDLE:
					if (transmitOn_r && !curDrained)
						state_r <= AOF_READ;
				AOF_READ:
					if (memGnt)
						state_r <= AOF_WAIT;
				AOF_WAIT:
					if (memRvalid) begin
						if (bufEnd) begin
							offset_r <= 32'h0000_0000;
							firstCurrent_r <= !firstCurrent_r;
						end else
							offset_r <= offset_r +
								(fmt_r[1] ? 32'h2 : 32'h4);
						if (slot_r == lastSlot) begin
							slot_r <= 3'h0;
							state_r <= AOF_HAND;
						end else begin
							slot_r <= slot_r + 3'h1;
							state_r <= AOF_IDLE;
						end
					end
				AOF_HAND:
					// hold until consumed
					// Leave on the edge that loads the lanes, so one frame
					// is handed over exactly once.
					if (frameReq)
						state_r <= AOF_IDLE;
				default:
					state_r <= AOF_IDLE;
			endcase
		end
	end

	// Stage samples; mono copies left into right, idle lanes get {signInv_r, 0}.
	// mono duplicates
	generate
		for (genvar i = 0; i < 4; i++) begin : g_lane
			always_ff @(posedge clk) begin
				if (unitRst || (state_r == AOF_HAND && frameReq)) begin
					stageL[i] <= {signInv_r, 31'h00000000};
					stageR[i] <= {signInv_r, 31'h00000000};
				end else if (state_r == AOF_WAIT && memRvalid) begin
					if (fmt_r[0]) begin
						if (slot_r == 3'(2 * i))
							stageL[i] <= sample;
						if (slot_r == 3'(2 * i + 1))
							stageR[i] <= sample;
					end else if (slot_r == 3'(i)) begin
						stageL[i] <= sample;
						stageR[i] <= sample;
					end
				end
			end
			// Frame outputs update only on hand-off or unit reset, so they stay stable.
			always_ff @(posedge clk) begin
				if (unitRst) begin
					laneLeft[i]  <= 32'h0000_0000;
					laneRight[i] <= 32'h0000_0000;
				end else if (state_r == AOF_HAND && frameReq) begin
					// idle lanes inverted
					// Software may set the invert bit after the staging
					// was cleared, so idle lanes use the live setting.
					laneLeft[i]  <= (2'(i) > laneCount_r) ?
						{signInv_r, 31'h00000000} : stageL[i];
					laneRight[i] <= (2'(i) > laneCount_r) ?
						{signInv_r, 31'h00000000} : stageR[i];
				end
			end
		end
	endgenerate

	// codec fields untouched
	// Control fields are inserted downstream, beyond this inversion.
	always_ff @(posedge clk) begin
		if (unitRst)
			frameValid <= 1'b0;
		else
			frameValid <= (state_r == AOF_HAND) && frameReq;
	end

	////////////////////////////////////////////////////////////////////////
	// Status flags; a set in the same cycle as an acknowledge wins.

	logic endFirst;                        // Buffer one just drained.
	logic endSecond;                       // Buffer two just drained.
	assign endFirst  = (state_r == AOF_WAIT) && memRvalid && bufEnd
		&& firstCurrent_r;
	assign endSecond = (state_r == AOF_WAIT) && memRvalid && bufEnd
		&& !firstCurrent_r;

	always_ff @(posedge clk) begin
		if (unitRst) begin
			firstDrained_r  <= 1'b0;
			secondDrained_r <= 1'b0;
		end else begin
			firstDrained_r  <= endFirst  || (firstDrained_r && !first_refill_ack);
			secondDrained_r <= endSecond || (secondDrained_r && !second_refill_ack);
		end
	end

	// Starved while the formatter asks and the current buffer is drained.
	// sticky underrun
	always_ff @(posedge clk) begin
		if (unitRst)
			underrun_r <= 1'b0;
		else
			underrun_r <= (transmitOn_r && frameReq && curDrained
				&& state_r == AOF_IDLE) || (underrun_r && !ackUdr);
	end

	assign irqReq = (firstDrained_r && firstDrainIrqEn_r)
		|| (secondDrained_r && secondDrainIrqEn_r)
		|| (underrun_r && udrIrqEn_r);

endmodule : aof_sample_fetch

// ===== testbench/aof_mem_model.sv
`timescale 1ns/1ns
// Memory: grants a held request, later returns one word.
module aof_mem_model (
	input  wire logic        clk,       // System clock.
	input  wire logic        slow,      // Adds wait states when high.
	input  wire logic        memReq,    // Read request.
	input  wire logic [31:0] memAddr,   // Word aligned byte address.
	output logic             memGnt,    // Request taken.
	output logic [31:0]      memRdata,  // Data, valid with memRvalid.
	output logic             memRvalid  // One-cycle data strobe.
);
	logic        pend_r = 1'b0; // A granted read awaits data.
	logic [31:0] addr_r;        // Address of that read.
	logic [3:0]  wait_r;        // Wait states left.
	// A hash of the address, so a skipped or repeated word shows.
	function automatic logic [31:0] wordAt(input logic [31:0] a);
		return a * 32'h9E37_79B1 + 32'h1357_9BDF;
	endfunction : wordAt
	initial memGnt = 1'b0;
	initial memRvalid = 1'b0;
	initial memRdata = 32'h0;
	// Outside a strobe the data bus flips, so stale data never matches.
	always @(posedge clk) begin
		memGnt <= 1'b0;
		memRvalid <= 1'b0;
		memRdata <= ~memRdata;
		if (pend_r && wait_r == 4'h0) begin
			memRvalid <= 1'b1;
			memRdata <= wordAt(addr_r);
			pend_r <= 1'b0;
		end else if (pend_r)
			wait_r <= wait_r - 4'h1;
		else if (memReq && !memGnt)
			memGnt <= 1'b1;
		else if (memReq) begin
			pend_r <= 1'b1;
			addr_r <= memAddr;
			wait_r <= slow ? 4'h5 : 4'h0;
		end
	end
endmodule : aof_mem_model

// ===== testbench/aof_sample_fetch_assertions.sv
`timescale 1ns/1ns
module aof_sample_fetch_chk
	import aof_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        cpuRst,
	input wire logic [3:0]  regAddr,
	input wire logic [31:0] regWdata,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [31:0] regRdata,
	input wire logic [31:0] memAddr,
	input wire logic        memReq,
	input wire logic        memGnt,
	input wire logic        memRvalid,
	input wire logic        frameValid,
	input wire logic [31:0] laneLeft  [4],
	input wire logic [31:0] laneRight [4],
	input wire logic        irqReq,
	input wire logic [63:0] timestamp
);
	logic       softWr;    // Software reset request in this cycle.
	logic [2:0] softAge_r; // Recent resets; lanes may clear without a frame.
	assign softWr = regWr && regAddr == REG_CTL && regWdata == SOFT_RESET_VALUE;
	// History of software resets, so the lane check can step aside.
	always_ff @(posedge clk) begin
		if (!rst_n)
			softAge_r <= 3'h0;
		else
			softAge_r <= {softAge_r[1:0], softWr};
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	/////////////////////////////////////////
	// refill acks read zero
	AST_ACK_ZERO:
		assert property (regRd && regAddr == REG_CTL |=>
			!regRdata[CTL_FIRST_REFILL_ACK] && !regRdata[CTL_SECOND_REFILL_ACK]) else $error("ack read 1");
	AST_SOFT_RESET:
		assert property (softWr |-> ##3 (!memReq && !frameValid && !irqReq) [*4])
		else $error("unit busy after software reset");
	AST_TS_CLEAR:
		assert property (cpuRst |=> timestamp == 64'h0) else $error("ts kept");
	// counter keeps running
	// The edge that still sees chip reset clears the count, so skip it.
	AST_TS_COUNT:
		assert property (rst_n && !cpuRst |=>
			timestamp == $past(timestamp) + 64'h1)
		else $error("timestamp skipped");
	AST_FRAME_PULSE:
		assert property (frameValid |=> !frameValid) else $error("double frame");
	AST_FRAME_HOLD:
		assert property (!frameValid && softAge_r == 3'h0 |->
			$stable(laneLeft[0]) && $stable(laneRight[3]))
		else $error("lane changed without frame");
	AST_MEM_HOLD:
		assert property (memReq && !memGnt && !softWr && softAge_r == 3'h0
			|=> memReq && $stable(memAddr)) else $error("request dropped");
	// acknowledge drops request
	// A drain in the same cycle wins over the acknowledge, so that cycle
	// is left out, as is an enabled underrun that may still be starving.
	AST_IRQ_ACK:
		assert property (regWr && regAddr == REG_CTL && !regWdata[CTL_RESET]
			&& regWdata[CTL_FIRST_REFILL_ACK] && regWdata[CTL_SECOND_REFILL_ACK]
			&& !regWdata[CTL_UDRINT] && !memRvalid
			|=> !irqReq) else $error("irq after acknowledge");
	AST_IRQ_CAUSE:
		assert property (irqReq && regRd && regAddr == REG_STATUS |=>
			regRdata[3:1] != 3'h0) else $error("irq without flag");
endmodule : aof_sample_fetch_chk
bind aof_sample_fetch aof_sample_fetch_chk u_chk (.clk(clk), .rst_n(rst_n),
	.cpuRst(cpuRst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
	.regRd(regRd), .regRdata(regRdata), .memAddr(memAddr), .memReq(memReq),
	.memGnt(memGnt), .memRvalid(memRvalid), .frameValid(frameValid),
	.laneLeft(laneLeft), .laneRight(laneRight), .irqReq(irqReq),
	.timestamp(timestamp));

// ===== testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top
	import aof_pkg::*;
;
	logic        clk, rst_n, cpuRst, regWr, regRd, memReq, memGnt, memRvalid;
	logic        frameReq, frameValid, irqReq, slow;
	logic [3:0]  regAddr;
	logic [31:0] regWdata, regRdata, memAddr, memRdata;
	logic [31:0] laneLeft [4];
	logic [31:0] laneRight [4];
	logic [63:0] timestamp;
	int          numErrors, testsRun, cycles;
	aof_sample_fetch u_dut (.clk(clk), .rst_n(rst_n), .cpuRst(cpuRst),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .memAddr(memAddr), .memReq(memReq),
		.memGnt(memGnt), .memRdata(memRdata), .memRvalid(memRvalid),
		.frameReq(frameReq), .frameValid(frameValid), .laneLeft(laneLeft),
		.laneRight(laneRight), .irqReq(irqReq), .timestamp(timestamp));
	aof_mem_model u_mem (.clk(clk), .slow(slow), .memReq(memReq),
		.memAddr(memAddr), .memGnt(memGnt), .memRdata(memRdata),
		.memRvalid(memRvalid));
	/////////////////////////////////////////
	always #4 clk = ~clk;
	// Slow runs also stall the formatter, so lanes must hold.
	always @(posedge clk) frameReq <= !slow || cycles[2];
	// Hang guard, far above the roughly 8600 cycles needed.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			numErrors++;
			finishTest();
		end
	end
	task automatic finishTest();
		$display("Comparisons %0d, mismatches %0d", testsRun, numErrors);
		if (numErrors == 0 && testsRun > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : finishTest
	task automatic check(input logic [63:0] got, exp, input string what);
		testsRun++;
		if (got !== exp) begin
			numErrors++;
			$display("BAD %0t %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] m, e,
		input string what);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(posedge clk);
		check(regRdata & m, e, what);
	endtask : rd
	// Sample n of the run, buffers alternating every perBuf samples.
	function automatic logic [31:0] expSample(input int n, input logic [1:0] f,
		input logic le, inv, input int perBuf);
		logic [31:0] a, w;
		logic [15:0] h;
		a = ((n / perBuf) % 2 ? 32'h0000_8040 : 32'h0000_1000)
			+ 32'((n % perBuf) * (f[1] ? 2 : 4));
		w = u_mem.wordAt({a[31:2], 2'h0});
		// Byte lanes are little endian: the lowest address is bits 7:0.
		h = a[1] ? w[31:16] : w[15:0];
		if (f[1])
			w = {le ? h : {h[7:0], h[15:8]}, 16'h0};
		else if (!le)
			w = {w[7:0], w[15:8], w[23:16], w[31:24]};
		return w ^ {inv, 31'h0};
	endfunction : expSample
	task automatic tsCheck();
		logic [63:0] t;
		wr(REG_CTL, 32'h0000_1800);
		cpuRst <= 1'b1;
		@(posedge clk);
		cpuRst <= 1'b0;
		@(posedge clk);
		check(timestamp, 64'h0, "timestamp cleared");
		rd(REG_CTL, '1, 32'h0000_1800, "control kept");
		t = timestamp;
		wr(REG_CTL, SOFT_RESET_VALUE);
		check(timestamp, t + 64'h2, "timestamp kept");
	endtask : tsCheck
	// Stream both buffers dry, then check flags, underrun and acknowledge.
	task automatic runCfg(input logic [1:0] f, lc, input logic le, inv, sl,
		input int sz);
		int perBuf, spf, n, to, j;
		logic [31:0] ctl, idle;
		perBuf = sz * (f[0] ? 2 : 1);
		spf = (lc + 1) * (f[0] ? 2 : 1);
		idle = {inv, 31'h0};
		ctl = {19'h0, lc, f, 5'h0, 1'b1, inv, le, 1'b1};
		wr(REG_CTL, SOFT_RESET_VALUE);
		repeat (8) @(posedge clk);
		rd(REG_CTL, '1, 32'h0, "control after reset");
		rd(REG_STATUS, 32'hF, 32'h1, "status after reset");
		slow <= sl;
		wr(REG_FIRST_BUFFER_BASE, 32'h0000_1000);
		wr(REG_SECOND_BUFFER_BASE, 32'h0000_8040);
		wr(REG_SIZE, sz);
		wr(REG_CTL, ctl);
		n = 0;
		repeat (2 * perBuf / spf) begin
			to = 0;
			do begin
				@(posedge clk);
				to++;
			end while (frameValid !== 1'b1 && to < 400);
			for (j = 0; j < 4; j++) begin
				check(laneLeft[j], j > lc ? idle : expSample(n + (f[0] ? 2 * j : j),
					f, le, inv, perBuf), "left lane");
				check(laneRight[j], j > lc ? idle : expSample(n + (f[0] ? 2 * j + 1
					: j), f, le, inv, perBuf), "right lane");
			end
			n += spf;
		end
		to = 0;
		repeat (60) begin
			@(posedge clk);
			if (frameValid === 1'b1)
				to++;
		end
		check(to, 0, "frames in underrun");
		rd(REG_STATUS, 32'hE, 32'hE, "drained and underrun");
		check(irqReq, 1'b1, "drain interrupt");
		// refill acknowledged
		// Buffers first: while still starved, a frame request in the
		// same cycle would set the underrun flag again over its ack.
		wr(REG_CTL, ctl | 32'h0C0);
		check(irqReq, 1'b0, "interrupt acknowledged");
		wr(REG_CTL, ctl | 32'h100);
		rd(REG_STATUS, 32'hE, 32'h0, "flags acknowledged");
		rd(REG_CTL, '1, ctl, "acks read zero");
	endtask : runCfg
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		{cpuRst, regWr, regRd, frameReq, slow} = 5'h0;
		regAddr = 4'h0;
		regWdata = 32'h0;
		{numErrors, testsRun, cycles} = {32'h0, 32'h0, 32'h0};
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(REG_STATUS, '1, 32'h1, "status at reset");
		rd(REG_FIRST_BUFFER_BASE, '1, 32'h0, "base at reset");
		rd(4'hF, '1, 32'h0, "unmapped read");
		tsCheck();
		runCfg(AOF_MONO32, 2'h0, 1'b0, 1'b0, 1'b0, 64);
		runCfg(AOF_STEREO32, 2'h1, 1'b1, 1'b1, 1'b1, 64);
		runCfg(AOF_MONO16, 2'h2, 1'b0, 1'b1, 1'b0, 192);
		runCfg(AOF_STEREO16, 2'h3, 1'b1, 1'b0, 1'b1, 64);
		finishTest();
	end
endmodule : tb_top
